// ---- pkg/adcsc_defines.vh ----
`ifndef ADCSC_DEFINES_VH
`define ADCSC_DEFINES_VH
// register offsets (word index on the plain port)
`define ADCSC_ADDR_CTRL      4'h0
`define ADCSC_ADDR_SEL       4'h1
`define ADCSC_ADDR_RESULT    4'h2
`define ADCSC_ADDR_STATUS    4'h3
// control register field positions
`define ADCSC_B_DONE         0
`define ADCSC_B_SAMPLE_ENABLE         1
`define ADCSC_B_SAMPLE_AUTO_START         2
`define ADCSC_B_SIM          3
`define ADCSC_B_TRIG_LO      5
`define ADCSC_B_TRIG_HI      7
`define ADCSC_B_FMT_LO       8
`define ADCSC_B_FMT_HI       9
`define ADCSC_B_RES          10
`define ADCSC_CTRL_RESET     16'h0000
// select register: channel count field
`define ADCSC_B_CHPS_LO      0
`define ADCSC_B_CHPS_HI      1
// trigger source codes
`define ADCSC_TRIG_SW        3'h0
`define ADCSC_TRIG_PIN       3'h1
`define ADCSC_TRIG_TMR       3'h2
`define ADCSC_TRIG_PWM       3'h3
`define ADCSC_TRIG_AUTO      3'h7
// output format codes
`define ADCSC_FMT_INT        2'h0
`define ADCSC_FMT_SINT       2'h1
`define ADCSC_FMT_FRAC       2'h2
`define ADCSC_FMT_SFRAC      2'h3
// timing
`define ADCSC_AUTO_SAMPLE_NS 160
`define ADCSC_CLK_NS         10
`define ADCSC_AUTO_CYCLES    ((`ADCSC_AUTO_SAMPLE_NS + `ADCSC_CLK_NS - 1) / `ADCSC_CLK_NS)
`define ADCSC_CONV_CYCLES    14
`endif

// ---- rtl/adcsc_control.v ----
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "adcsc_defines.vh"

module adcsc_control #(
  parameter CONV_CYCLES = `ADCSC_CONV_CYCLES,
  parameter AUTO_CYCLES = `ADCSC_AUTO_CYCLES
) (
  input  wire        clk_i,
  input  wire        sys_rst_i,
  input  wire [3:0]  addr_i,
  input  wire [15:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [15:0] rdata_o,
  input  wire        external_interrupt_zero_pin_i,
  input  wire        general_timer_compare_i,
  input  wire        motor_control_pwm_end_i,
  input  wire [11:0] conv_data_i,
  output reg  [3:0]  sample_hold_o,
  output reg  [1:0]  convert_channel_o,
  output reg         converting_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam ST_IDLE   = 2'b00;
  localparam ST_SAMPLE = 2'b01;
  localparam ST_CONV   = 2'b10;

  // ----------------------------------------------------------------
  // programmer's view
  // ----------------------------------------------------------------
  // word 0, control:
  //   bit 0      done flag, set by the sequencer, cleared by a zero write
  //   bit 1      sample enable, one while the amplifiers track the input
  //   bit 2      auto start, re-arm sampling after the last conversion
  //   bit 3      simultaneous sampling, forced low in 12-bit mode
  //   bit 4      spare, reads zero
  //   bits 7:5   trigger source that ends sampling
  //   bits 9:8   output word format
  //   bit 10     resolution, one for 12-bit single channel
  //   bits 15:11 spare, read zero
  // word 1, channel count:
  //   bits 1:0   00 one channel, 01 two channels, 1x four channels
  // word 2, formatted result of the last channel of a round
  // word 3, status:
  //   bits 15:4  raw converter word of the latest conversion
  //   bits 2:1   channel index of the sequencer
  //   bit 0      converting flag as seen on the output pin
  // unmapped words read zero and ignore writes
  //
  // sequencer:
  //   idle    waits for software to raise sample enable
  //   sample  tracks the inputs until the chosen trigger fires
  //   conv    converts channel zero up to the last channel in turn,
  //           spending CONV_CYCLES clocks on each one
  // when auto start is set the sequencer goes straight back to sample
  // after the last channel, else it parks in idle
  //
  // hazards a user must know:
  //   a write that sets sample enable while a round is running is
  //   ignored; the write is not queued
  //   a zero write to sample enable only ends sampling with the
  //   software trigger; with any other source hardware ends it
  //   reserved trigger codes leave the block sampling forever, so
  //   software has to move to a valid code to get a result
  //   clearing done never stops a round; a completion in the same
  //   cycle as a clear leaves done set
  //   the result word is formatted with the format and resolution in
  //   force at the end of the round, not at its start

  reg [1:0]  state;
  reg [2:0]  trig_sel;
  reg [1:0]  fmt_sel;
  reg        res_sel;
  reg        sim_sel;
  reg        auto_start;
  reg        sample_enable;
  reg        done;
  reg [1:0]  chan_count;
  reg [15:0] result;
  reg [7:0]  conv_cnt;
  reg [7:0]  auto_cnt;
  reg [1:0]  chan_idx;
  reg [2:0]  pin_sync;
  reg        pin_seen;
  reg [11:0] raw;

  // ----------------------------------------------------------------
  // result formatting
  // ----------------------------------------------------------------
  function [15:0] fmt_word;
    input        res12;
    input [1:0]  fmt;
    input [11:0] d;
    begin
      if (res12) begin
        case (fmt)
          `ADCSC_FMT_INT:  fmt_word = {4'h0, d};
          `ADCSC_FMT_SINT: fmt_word = {{5{~d[11]}}, d[10:0]};
          `ADCSC_FMT_FRAC: fmt_word = {d, 4'h0};
          default:         fmt_word = {~d[11], d[10:0], 4'h0};
        endcase
      end else begin
        case (fmt)
          `ADCSC_FMT_INT:  fmt_word = {6'h00, d[9:0]};
          `ADCSC_FMT_SINT: fmt_word = {{7{~d[9]}}, d[8:0]};
          `ADCSC_FMT_FRAC: fmt_word = {d[9:0], 6'h00};
          default:         fmt_word = {~d[9], d[8:0], 6'h00};
        endcase
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchroniser and edge
  // ----------------------------------------------------------------
  // three stages; a change counts once stages two and three agree
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_sync <= 3'h0;
      pin_seen <= 1'b0;
    end else begin
      pin_sync <= {pin_sync[1:0], external_interrupt_zero_pin_i};
      if (pin_sync[1] == pin_sync[2])
        pin_seen <= pin_sync[2];
    end
  end

  wire pin_rise = (pin_sync[1] == pin_sync[2]) & pin_sync[2] & ~pin_seen;

  // ----------------------------------------------------------------
  // trigger selection
  // ----------------------------------------------------------------
  reg hw_trig;
  always @* begin
    case (trig_sel)
      `ADCSC_TRIG_PIN:  hw_trig = pin_rise;
      `ADCSC_TRIG_TMR:  hw_trig = general_timer_compare_i;
      `ADCSC_TRIG_PWM:  hw_trig = motor_control_pwm_end_i;
      `ADCSC_TRIG_AUTO: hw_trig = (auto_cnt >= AUTO_CYCLES[7:0] - 8'h01);
      default:          hw_trig = 1'b0;
    endcase
  end

  wire ctrl_wr  = wr_i & (addr_i == `ADCSC_ADDR_CTRL);
  wire sw_set   = ctrl_wr & wdata_i[`ADCSC_B_SAMPLE_ENABLE] & ~sample_enable;
  wire sw_end   = ctrl_wr & ~wdata_i[`ADCSC_B_SAMPLE_ENABLE] & sample_enable & (trig_sel == `ADCSC_TRIG_SW);
  wire start_cv = (state == ST_SAMPLE) & (sw_end | ((trig_sel != `ADCSC_TRIG_SW) & hw_trig));

  // number of the last channel converted in one cycle
  function [1:0] last_chan;
    input [1:0] cnt;
    begin
      if (cnt[1])
        last_chan = 2'h3;
      else if (cnt[0])
        last_chan = 2'h1;
      else
        last_chan = 2'h0;
    end
  endfunction

  // end of the final channel; 12-bit mode only ever uses channel zero
  wire last_cv  = (state == ST_CONV) & (conv_cnt == CONV_CYCLES[7:0] - 8'h01) &
                  (res_sel | (chan_idx == last_chan(chan_count)));

  // ----------------------------------------------------------------
  // register writes and sequencer
  // ----------------------------------------------------------------
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state         <= ST_IDLE;
      trig_sel      <= 3'h0;
      fmt_sel       <= 2'h0;
      res_sel       <= 1'b0;
      sim_sel       <= 1'b0;
      auto_start    <= 1'b0;
      sample_enable <= 1'b0;
      done          <= 1'b0;
      chan_count    <= 2'h0;
      result        <= 16'h0000;
      conv_cnt      <= 8'h00;
      auto_cnt      <= 8'h00;
      chan_idx      <= 2'h0;
      raw           <= 12'h000;
    end else begin
      if (ctrl_wr) begin
        trig_sel   <= wdata_i[`ADCSC_B_TRIG_HI:`ADCSC_B_TRIG_LO];
        fmt_sel    <= wdata_i[`ADCSC_B_FMT_HI:`ADCSC_B_FMT_LO];
        res_sel    <= wdata_i[`ADCSC_B_RES];
        sim_sel    <= wdata_i[`ADCSC_B_SIM] & ~wdata_i[`ADCSC_B_RES];
        auto_start <= wdata_i[`ADCSC_B_SAMPLE_AUTO_START];
      end
      if (wr_i & (addr_i == `ADCSC_ADDR_SEL))
        chan_count <= wdata_i[`ADCSC_B_CHPS_HI:`ADCSC_B_CHPS_LO];
      if (ctrl_wr & ~wdata_i[`ADCSC_B_DONE])
        done <= 1'b0;
      auto_cnt <= (state == ST_SAMPLE) ? auto_cnt + 8'h01 : 8'h00;
      case (state)
        ST_IDLE: begin
          if (sw_set) begin
            sample_enable <= 1'b1;
            state         <= ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          if (start_cv) begin
            sample_enable <= 1'b0;
            state         <= ST_CONV;
            conv_cnt      <= 8'h00;
            chan_idx      <= 2'h0;
            done          <= 1'b0;
          end
        end
        ST_CONV: begin
          conv_cnt <= conv_cnt + 8'h01;
          if (conv_cnt == CONV_CYCLES[7:0] - 8'h01) begin
            raw      <= conv_data_i;
            conv_cnt <= 8'h00;
            if (last_cv) begin
              result <= fmt_word(res_sel, fmt_sel, conv_data_i);
              done   <= 1'b1;
              if (auto_start) begin
                sample_enable <= 1'b1;
                state         <= ST_SAMPLE;
              end else begin
                state <= ST_IDLE;
              end
            end else begin
              chan_idx <= chan_idx + 2'h1;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // sample/hold and channel outputs
  // ----------------------------------------------------------------
  reg [3:0] next_hold;
  always @* begin
    next_hold = 4'h0;
    if (state == ST_SAMPLE || (state == ST_IDLE && sw_set)) begin
      if (res_sel)
        next_hold = 4'h1;
      else if (sim_sel && chan_count[1])
        next_hold = 4'hf;
      else if (sim_sel && chan_count[0])
        next_hold = 4'h3;
      else
        next_hold = 4'h1;
    end
    if (start_cv)
      next_hold = 4'h0;
  end

  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sample_hold_o     <= 4'h0;
      convert_channel_o <= 2'h0;
      converting_o      <= 1'b0;
    end else begin
      sample_hold_o     <= next_hold;
      convert_channel_o <= chan_idx;
      converting_o      <= (state == ST_CONV);
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  // timing seen by software:
  //   a read strobe in cycle n gives data in cycle n+1 only; the port
  //   returns zero in every other cycle, so a late capture reads zero
  //   a write in cycle n is visible to a read strobed in cycle n+1
  //   the status word shows the converting flag one clock behind the
  //   sequencer, the same as the pin does
  // the raw word keeps the last conversion of any channel, which helps
  // when checking a sequential round channel by channel
  // strobes may follow each other with no gap; the port never stalls
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      case (addr_i)
        `ADCSC_ADDR_CTRL:   rdata_o <= {5'h00, res_sel, fmt_sel, trig_sel, 1'b0, sim_sel,
                                        auto_start, sample_enable, done};
        `ADCSC_ADDR_SEL:    rdata_o <= {14'h0000, chan_count};
        `ADCSC_ADDR_RESULT: rdata_o <= result;
        `ADCSC_ADDR_STATUS: rdata_o <= {raw, 1'b0, chan_idx, converting_o};
        default:            rdata_o <= 16'h0000;
      endcase
    end else begin
      rdata_o <= 16'h0000;
    end
  end

endmodule // adcsc_control
`default_nettype wire

// ---- verification/adcsc_control_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
module adcsc_control_sva #(
  parameter CONV_CYCLES = 2,
  parameter AUTO_CYCLES = 2
) (
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  input wire logic [3:0]  addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        external_interrupt_zero_pin_i,
  input wire logic        general_timer_compare_i,
  input wire logic        motor_control_pwm_end_i,
  input wire logic [3:0]  sample_hold_o,
  input wire logic [1:0]  convert_channel_o,
  input wire logic        converting_o
);
  logic [2:0] trig;
  logic [1:0] chps;
  logic       sample_auto_start, sim, res;
  logic       smp;
  assign smp = sample_hold_o != 4'h0;
  // shadow of software-written fields
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      {res, trig, sim, sample_auto_start, chps} <= 8'h00;
    end else if (wr_i && addr_i == 4'h0) begin
      {res, trig, sim, sample_auto_start} <= {wdata_i[10], wdata_i[7:5], wdata_i[3:2]};
    end else if (wr_i && addr_i == 4'h1) begin
      chps <= wdata_i[1:0];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_hold;
    ##[1:3] sample_hold_o == 4'h0;
  endsequence
  pwm_trigger_a: assert property (trig == 3'h3 && smp && motor_control_pwm_end_i |-> s_hold)
    else $error("pwm end did not stop sampling");
  timer_trigger_a: assert property (trig == 3'h2 && smp && general_timer_compare_i |-> s_hold)
    else $error("timer compare did not stop sampling");
  pin_trigger_a: assert property (trig == 3'h1 && smp && $rose(external_interrupt_zero_pin_i)
    |-> ##[1:8] sample_hold_o == 4'h0)
    else $error("pin edge did not stop sampling");
  reserved_code_a: assert property (trig inside {3'h4, 3'h5, 3'h6} && smp && !wr_i |=> smp)
    else $error("reserved code ended sampling");
  sw_end_a: assert property (trig == 3'h0 && smp && wr_i && addr_i == 4'h0 && wdata_i[7:5] == 3'h0
    && !wdata_i[1] |-> s_hold)
    else $error("software clear did not stop sampling");
  hold_on_conv_a: assert property ($rose(converting_o) |-> sample_hold_o == 4'h0)
    else $error("sampling while converting");
  auto_restart_a: assert property (sample_auto_start && $fell(converting_o) |-> ##[0:2] smp)
    else $error("no sampling restart");
  sim_four_a: assert property (sim && !res && chps[1] && smp |-> sample_hold_o == 4'hf)
    else $error("four channels not sampled together");
  sim_two_a: assert property (sim && !res && chps == 2'h1 && smp |-> sample_hold_o == 4'h3)
    else $error("two channels not sampled together");
  single_chan_a: assert property (res && converting_o |-> convert_channel_o == 2'h0)
    else $error("channel other than zero in 12-bit mode");
endmodule // adcsc_control_sva
`default_nettype wire

// ---- verification/adcsc_control_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module adcsc_control_tb;
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        external_interrupt_zero_pin_i = 1'b0;
  logic        general_timer_compare_i = 1'b0;
  logic        motor_control_pwm_end_i = 1'b0;
  logic [3:0]  addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic [11:0] conv_data_i = 12'h000;
  logic [15:0] rdata_o, r, c;
  logic [3:0]  sample_hold_o;
  logic [1:0]  convert_channel_o;
  logic        converting_o;
  int          num_errors = 0;
  int          comparisons = 0;
  int          cycles = 0;
  adcsc_control #(.CONV_CYCLES(2), .AUTO_CYCLES(2)) i_adcsc_control (.*);
  // clock and hang guard
  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      wrap_up();
    end
  end
  // register port cycles
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 r = rdata_o;
  endtask
  task automatic wait_done();
    for (int i = 0; i < 40; i++) begin
      rd(4'h0);
      if (r[0] === 1'b1) break;
    end
  endtask
  // expected result word
  function automatic logic [15:0] fmt_exp(input logic [2:0] m, input logic [11:0] d);
    case (m)
      3'h0: return {6'h00, d[9:0]};
      3'h1: return {{7{~d[9]}}, d[8:0]};
      3'h2: return {d[9:0], 6'h00};
      3'h3: return {~d[9], d[8:0], 6'h00};
      3'h4: return {4'h0, d};
      3'h5: return {{5{~d[11]}}, d[10:0]};
      3'h6: return {d, 4'h0};
      default: return {~d[11], d[10:0], 4'h0};
    endcase
  endfunction
  task automatic wrap_up();
    $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(4'h0); `CHK(r, 16'h0000)
    rd(4'h7); `CHK(r, 16'h0000)
    for (int k = 0; k < 16; k++) begin
      @(posedge clk_i) conv_data_i <= k[0] ? 12'hca5 : 12'h35a;
      c = {5'h00, k[3:1], 8'h00};
      wr(4'h0, c | 16'h0002);
      wr(4'h0, c);
      wait_done(); `CHK(r[0], 1'b1)
      rd(4'h2); `CHK(r, fmt_exp(k[3:1], k[0] ? 12'hca5 : 12'h35a))
    end
    $display("format test done");
    wr(4'h0, 16'h0000);
    rd(4'h0); `CHK(r, 16'h0000)
    wr(4'h0, 16'h0002);
    wr(4'h0, 16'h0002);
    rd(4'h0); `CHK(r[1], 1'b1)
    wr(4'h0, 16'h0000);
    wait_done(); `CHK(r[1:0], 2'b01)
    for (int s = 1; s < 8; s++) begin
      wr(4'h0, {8'h00, s[2:0], 5'h02});
      @(posedge clk_i);
      motor_control_pwm_end_i <= s == 3 || (s > 3 && s < 7);
      general_timer_compare_i <= s == 2 || (s > 3 && s < 7);
      external_interrupt_zero_pin_i <= s == 1 || (s > 3 && s < 7);
      @(posedge clk_i);
      motor_control_pwm_end_i <= 1'b0;
      general_timer_compare_i <= 1'b0;
      repeat (5) @(posedge clk_i);
      external_interrupt_zero_pin_i <= 1'b0;
      if (s > 3 && s < 7) begin
        rd(4'h0); `CHK(r[1:0], 2'b10)
        wr(4'h0, 16'h0000);
        wr(4'h0, 16'h0000);
      end
      wait_done(); `CHK(r[1:0], 2'b01)
    end
    $display("trigger test done");
    wr(4'h0, 16'h00e6);
    wait_done(); `CHK(r[1:0], 2'b11)
    repeat (30) @(posedge clk_i);
    wr(4'h0, 16'h0000);
    wr(4'h0, 16'h0000);
    repeat (20) @(posedge clk_i);
    $display("auto start test done");
    for (int n = 1; n < 3; n++) begin
      wr(4'h1, {14'h0000, n[1:0]});
      wr(4'h0, 16'h0008);
      wr(4'h0, 16'h000a);
      @(posedge clk_i);
      #1 `CHK(sample_hold_o, n == 1 ? 4'h3 : 4'hf)
      wr(4'h0, 16'h0008);
      wait_done(); `CHK(r[0], 1'b1)
    end
    wr(4'h1, 16'h0002);
    wr(4'h0, 16'h0002);
    @(posedge clk_i);
    #1 `CHK(sample_hold_o, 4'h1)
    wr(4'h0, 16'h0000);
    @(posedge clk_i);
    #1 `CHK({converting_o, convert_channel_o}, 3'h4)
    wait_done(); `CHK(r[0], 1'b1)
    rd(4'h3); `CHK(r[2:1], 2'h3)
    wr(4'h0, 16'h0408);
    rd(4'h0); `CHK(r[3], 1'b0)
    $display("simultaneous test done");
    wrap_up();
  end
endmodule // adcsc_control_tb
bind adcsc_control adcsc_control_sva #(.CONV_CYCLES(CONV_CYCLES), .AUTO_CYCLES(AUTO_CYCLES)) i_adcsc_control_sva (.*);
`default_nettype wire
